// ---- inc/ubk_pkg.sv ----
// Constants and types shared by the user break unit.
// Assumes byte addresses on the register bus, one aligned 32-bit word per register.
package ubk_pkg;
  localparam int AW = 32;
  localparam int DW = 32;
  localparam int IDW = 8;
  localparam int BAW = 6;
  localparam int BEW = 4;
  // Register byte offsets.
  localparam logic [5:0] OFS_ADDR_A = 6'h00;
  localparam logic [5:0] OFS_SPACE_A = 6'h04;
  localparam logic [5:0] OFS_AMASK_A = 6'h08;
  localparam logic [5:0] OFS_CYC_A = 6'h0c;
  localparam logic [5:0] OFS_ADDR_B = 6'h10;
  localparam logic [5:0] OFS_SPACE_B = 6'h14;
  localparam logic [5:0] OFS_AMASK_B = 6'h18;
  localparam logic [5:0] OFS_CYC_B = 6'h1c;
  localparam logic [5:0] OFS_DATA_B = 6'h20;
  localparam logic [5:0] OFS_DMASK_B = 6'h24;
  localparam logic [5:0] OFS_CONTROL = 6'h28;
  // Control register bit positions.
  localparam int CTL_FLAG_A = 15;
  localparam int CTL_FLAG_B = 14;
  localparam int CTL_AFTER_A = 10;
  localparam int CTL_DCMP = 7;
  localparam int CTL_AFTER_B = 6;
  localparam int CTL_SEQ = 3;
  localparam int CTL_W = 16;
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [31:0] REG_RST = 32'h00000000;
  // Bus-cycle select fields.
  localparam int CS_SZ = 0;
  localparam int CS_RW = 2;
  localparam int CS_FD = 4;
  localparam int CS_W = 6;
  localparam logic [1:0] SZ_NONE = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_LONG = 2'h3;
  // Address mask register: two-bit code and an ID-ignore bit.
  localparam int AM_ID_IGN = 2;
  localparam int AM_W = 3;
  localparam logic [1:0] AM_NONE = 2'h0;
  localparam logic [1:0] AM_LOW10 = 2'h1;
  localparam logic [1:0] AM_LOW12 = 2'h2;
  localparam logic [31:0] MASK_LOW10 = 32'h000003ff;
  localparam logic [31:0] MASK_LOW12 = 32'h00000fff;
  localparam logic [31:0] MASK_ALL = 32'hffffffff;
  localparam logic [31:0] MASK_HALF = 32'h0000ffff;
  typedef enum logic [1:0] {
    UBK_IDLE = 2'b00,
    UBK_NEXT = 2'b01,
    UBK_SLOT = 2'b10,
    UBK_TARGET = 2'b11
  } ubk_trap_st_t;
endpackage

// ---- rtl/ubk_user_break.sv ----
// User break unit: two breakpoint channels on the core's fetch and data cycles.
// Assumes the core shows each confirmed instruction issue and each data cycle on
// sys_clk_i, and cancels the issued instruction when brk_trap_o rises one edge later.
//
// Contract
// - Match address and ID under channel masks.
// - Cycle select 00 never breaks.
// - Match flags stick until written zero.
// - Sequential: B breaks only after earlier A.
// - Sequential: B before or with A ignored.
// - Sequential: only flag B gets set.
// - Fetch channel; after-select picks trap timing.
// - Fetch breaks resolved per instruction address.
// - Before-break only on confirmed executing instruction.
// - Exception first; break on re-execution.
// - Delay slot before-break traps before branch.
// - After-break: trap before next; branch target.
// - Fetch on channel B ignores break data.
// - Operand size field selects compared address bits.
// - Data enable: address and data must match.
// - Before-break saves instruction or branch address.
// - After-break saves next or branch address.
// - Data address break traps before next.
// - Data value break saves next issued address.
// - Control clears at power-on and manual reset.
// - Data mask one excludes that bit.
`timescale 1ns/100ps
module ubk_user_break
  import ubk_pkg::*;
#(
  parameter int ASID_W = ubk_pkg::IDW
) (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire logic manual_rst_i,
  // Register bus, Avalon-MM slave.
  input wire logic [ubk_pkg::BAW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ubk_pkg::DW-1:0] avs_writedata_i,
  input wire logic [ubk_pkg::BEW-1:0] avs_byteenable_i,
  output logic [ubk_pkg::DW-1:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Confirmed instruction issue from the core.
  input wire logic issue_valid_i,
  input wire logic issue_excp_i,
  input wire logic [ubk_pkg::AW-1:0] issue_addr_i,
  input wire logic [ASID_W-1:0] issue_asid_i,
  input wire logic issue_is_dbranch_i,
  input wire logic issue_in_slot_i,
  input wire logic [ubk_pkg::AW-1:0] issue_branch_addr_i,
  // Data access cycles.
  input wire logic dacc_valid_i,
  input wire logic dacc_write_i,
  input wire logic [1:0] dacc_size_i,
  input wire logic [ubk_pkg::AW-1:0] dacc_addr_i,
  input wire logic [ASID_W-1:0] dacc_asid_i,
  input wire logic [ubk_pkg::DW-1:0] dacc_data_i,
  // Trap request to the core.
  output logic brk_trap_o,
  output logic [ubk_pkg::AW-1:0] brk_saved_pc_o
);
  import ubk_pkg::*;

  localparam int CH_A = 0;
  localparam int CH_B = 1;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [31:0] be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] be
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic [31:0] amask_of(input logic [1:0] code);
    logic [31:0] m;
    case (code)
      AM_NONE: m = REG_RST;
      AM_LOW10: m = MASK_LOW10;
      AM_LOW12: m = MASK_LOW12;
      default: m = MASK_ALL;
    endcase
    return m;
  endfunction

  // Low address bits ignored for an operand size.
  function automatic logic [31:0] size_mask(input logic [1:0] sz);
    logic [31:0] m;
    case (sz)
      SZ_WORD: m = 32'h00000001;
      SZ_LONG: m = 32'h00000003;
      default: m = REG_RST;
    endcase
    return m;
  endfunction

  function automatic logic addr_eq(
    input logic [31:0] a,
    input logic [31:0] ref_a,
    input logic [31:0] ign
  );
    return ((a ^ ref_a) & ~ign) == REG_RST;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register bus handshake.

  logic wait_r;
  logic wr_go;
  logic rd_go;
  logic [31:0] rd_val;
  logic [31:0] wmerge_old;
  logic [31:0] wmerge;

  // One wait cycle per access; the write lands when waitrequest is seen low.
  assign wr_go = avs_write_i & ~wait_r;
  assign rd_go = avs_read_i & wait_r;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~((avs_read_i | avs_write_i) & wait_r);
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata_o <= REG_RST;
    end else if (rd_go) begin
      avs_readdata_o <= rd_val;
    end
  end

  assign avs_waitrequest_o = wait_r;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers.

  logic [31:0] brk_addr_r [2];
  logic [ASID_W-1:0] brk_space_id_r [2];
  logic [AM_W-1:0] brk_addr_mask_r [2];
  logic [CS_W-1:0] brk_cycle_sel_r [2];
  logic [31:0] brk_data_b_r;
  logic [31:0] brk_data_mask_b_r;
  logic match_flag_a_r;
  logic match_flag_b_r;
  logic after_exec_sel_a_r;
  logic after_exec_sel_b_r;
  logic data_cmp_enable_r;
  logic sequential_sel_r;
  logic [CTL_W-1:0] ctl_rd;

  always_comb begin
    ctl_rd = CTL_RST;
    ctl_rd[CTL_FLAG_A] = match_flag_a_r;
    ctl_rd[CTL_FLAG_B] = match_flag_b_r;
    ctl_rd[CTL_AFTER_A] = after_exec_sel_a_r;
    ctl_rd[CTL_DCMP] = data_cmp_enable_r;
    ctl_rd[CTL_AFTER_B] = after_exec_sel_b_r;
    ctl_rd[CTL_SEQ] = sequential_sel_r;
  end

  always_comb begin
    case (avs_address_i)
      OFS_ADDR_A: rd_val = brk_addr_r[CH_A];
      OFS_SPACE_A: rd_val = 32'(brk_space_id_r[CH_A]);
      OFS_AMASK_A: rd_val = 32'(brk_addr_mask_r[CH_A]);
      OFS_CYC_A: rd_val = 32'(brk_cycle_sel_r[CH_A]);
      OFS_ADDR_B: rd_val = brk_addr_r[CH_B];
      OFS_SPACE_B: rd_val = 32'(brk_space_id_r[CH_B]);
      OFS_AMASK_B: rd_val = 32'(brk_addr_mask_r[CH_B]);
      OFS_CYC_B: rd_val = 32'(brk_cycle_sel_r[CH_B]);
      OFS_DATA_B: rd_val = brk_data_b_r;
      OFS_DMASK_B: rd_val = brk_data_mask_b_r;
      OFS_CONTROL: rd_val = 32'(ctl_rd);
      default: rd_val = REG_RST;
    endcase
  end

  // Old value of the addressed register, so byte enables keep untouched lanes.
  assign wmerge_old = rd_val;
  assign wmerge = be_merge(wmerge_old, avs_writedata_i, avs_byteenable_i);

  // Channel registers keep their value across a manual reset.
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int c = 0; c < 2; c++) begin
        brk_addr_r[c] <= REG_RST;
        brk_space_id_r[c] <= '0;
        brk_addr_mask_r[c] <= '0;
        brk_cycle_sel_r[c] <= '0;
      end
    end else if (wr_go) begin
      case (avs_address_i)
        OFS_ADDR_A: brk_addr_r[CH_A] <= wmerge;
        OFS_SPACE_A: brk_space_id_r[CH_A] <= wmerge[ASID_W-1:0];
        OFS_AMASK_A: brk_addr_mask_r[CH_A] <= wmerge[AM_W-1:0];
        OFS_CYC_A: brk_cycle_sel_r[CH_A] <= wmerge[CS_W-1:0];
        OFS_ADDR_B: brk_addr_r[CH_B] <= wmerge;
        OFS_SPACE_B: brk_space_id_r[CH_B] <= wmerge[ASID_W-1:0];
        OFS_AMASK_B: brk_addr_mask_r[CH_B] <= wmerge[AM_W-1:0];
        OFS_CYC_B: brk_cycle_sel_r[CH_B] <= wmerge[CS_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      brk_data_b_r <= REG_RST;
      brk_data_mask_b_r <= REG_RST;
    end else if (wr_go && avs_address_i == OFS_DATA_B) begin
      brk_data_b_r <= wmerge;
    end else if (wr_go && avs_address_i == OFS_DMASK_B) begin
      brk_data_mask_b_r <= wmerge;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel comparators.

  logic [1:0] f_hit;
  logic [1:0] d_hit;
  logic [1:0] hit;
  logic [31:0] lanes;
  logic data_ok;

  // Byte and word accesses compare only the low half of the data.
  assign lanes = (dacc_size_i == SZ_LONG) ? MASK_ALL : MASK_HALF;
  // A set mask bit drops that data bit from the comparison.
  assign data_ok = ((dacc_data_i ^ brk_data_b_r) & ~brk_data_mask_b_r & lanes) == REG_RST;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [1:0] fd;
    logic [1:0] rw;
    logic [1:0] sz;
    logic [31:0] am;
    logic id_ign;
    logic f_id;
    logic d_id;
    logic d_rw;
    logic [1:0] eff_sz;
    logic d_val;

    assign fd = brk_cycle_sel_r[c][CS_FD +: 2];
    assign rw = brk_cycle_sel_r[c][CS_RW +: 2];
    assign sz = brk_cycle_sel_r[c][CS_SZ +: 2];
    assign am = amask_of(brk_addr_mask_r[c][1:0]);
    assign id_ign = brk_addr_mask_r[c][AM_ID_IGN];
    assign f_id = id_ign | (issue_asid_i == brk_space_id_r[c]);
    assign d_id = id_ign | (dacc_asid_i == brk_space_id_r[c]);

    // Fetch side is checked per issued instruction, never on the fetch pair,
    // so overrun fetches and faulting fetches are never seen.
    // A zero fetch/data or read/write field can never match.
    assign f_hit[c] = fd[0] & rw[0] & issue_valid_i & ~issue_excp_i & f_id
      & addr_eq(issue_addr_i, brk_addr_r[c], am);

    // Size field 00 follows the access; otherwise the access must be that size.
    assign eff_sz = (sz == SZ_NONE) ? dacc_size_i : sz;
    assign d_rw = dacc_write_i ? rw[1] : rw[0];
    // Only channel B takes the data comparison, and only on data cycles.
    assign d_val = (c != CH_B) | ~data_cmp_enable_r | data_ok;
    assign d_hit[c] = fd[1] & d_rw & dacc_valid_i & d_id & d_val
      & ((sz == SZ_NONE) | (sz == dacc_size_i))
      & addr_eq(dacc_addr_i, brk_addr_r[c], am | size_mask(eff_sz));

    assign hit[c] = f_hit[c] | d_hit[c];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencing and match flags.

  logic armed_r;
  logic go_a;
  logic go_b;
  logic set_a;
  logic set_b;
  logic ctl_wr;

  // Channel A arms the pair; B counts only on a later cycle.
  assign go_a = ~sequential_sel_r;
  assign go_b = ~sequential_sel_r | armed_r;
  // In sequential mode flag A stays untouched.
  assign set_a = hit[CH_A] & go_a;
  assign set_b = hit[CH_B] & go_b;

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      armed_r <= 1'b0;
    end else if (!sequential_sel_r || manual_rst_i) begin
      armed_r <= 1'b0;
    end else if (set_b) begin
      armed_r <= 1'b0;
    end else if (hit[CH_A]) begin
      armed_r <= 1'b1;
    end
  end

  assign ctl_wr = wr_go & (avs_address_i == OFS_CONTROL);

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      match_flag_a_r <= CTL_RST[CTL_FLAG_A];
      match_flag_b_r <= CTL_RST[CTL_FLAG_B];
      after_exec_sel_a_r <= CTL_RST[CTL_AFTER_A];
      after_exec_sel_b_r <= CTL_RST[CTL_AFTER_B];
      data_cmp_enable_r <= CTL_RST[CTL_DCMP];
      sequential_sel_r <= CTL_RST[CTL_SEQ];
    end else if (manual_rst_i) begin
      match_flag_a_r <= CTL_RST[CTL_FLAG_A];
      match_flag_b_r <= CTL_RST[CTL_FLAG_B];
      after_exec_sel_a_r <= CTL_RST[CTL_AFTER_A];
      after_exec_sel_b_r <= CTL_RST[CTL_AFTER_B];
      data_cmp_enable_r <= CTL_RST[CTL_DCMP];
      sequential_sel_r <= CTL_RST[CTL_SEQ];
    end else begin
      // A match in the clearing cycle keeps the flag set.
      match_flag_a_r <= set_a | (ctl_wr ? wmerge[CTL_FLAG_A] : match_flag_a_r);
      match_flag_b_r <= set_b | (ctl_wr ? wmerge[CTL_FLAG_B] : match_flag_b_r);
      if (ctl_wr) begin
        after_exec_sel_a_r <= wmerge[CTL_AFTER_A];
        after_exec_sel_b_r <= wmerge[CTL_AFTER_B];
        data_cmp_enable_r <= wmerge[CTL_DCMP];
        sequential_sel_r <= wmerge[CTL_SEQ];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trap timing.

  ubk_trap_st_t st_r;
  ubk_trap_st_t st_nxt;
  logic [31:0] held_pc_r;
  logic [31:0] held_pc_nxt;
  logic trap_nxt;
  logic [31:0] pc_nxt;
  logic bfr_hit;
  logic aft_hit;
  logic dat_hit;
  logic issue_ok;

  assign issue_ok = issue_valid_i & ~issue_excp_i;
  // Before-execution wins when both channels hit one instruction.
  assign bfr_hit = (f_hit[CH_A] & ~after_exec_sel_a_r & go_a)
    | (f_hit[CH_B] & ~after_exec_sel_b_r & go_b);
  assign aft_hit = (f_hit[CH_A] & after_exec_sel_a_r & go_a)
    | (f_hit[CH_B] & after_exec_sel_b_r & go_b);
  assign dat_hit = (d_hit[CH_A] & go_a) | (d_hit[CH_B] & go_b);

  always_comb begin
    st_nxt = st_r;
    held_pc_nxt = held_pc_r;
    trap_nxt = 1'b0;
    pc_nxt = brk_saved_pc_o;
    if (bfr_hit) begin
      // Slot instruction traps ahead of its branch.
      trap_nxt = 1'b1;
      pc_nxt = issue_in_slot_i ? issue_branch_addr_i : issue_addr_i;
      st_nxt = UBK_IDLE;
    end else begin
      case (st_r)
        UBK_IDLE: begin
        end
        UBK_NEXT: begin
          if (issue_ok) begin
            // Trap before the next instruction and save its address.
            trap_nxt = 1'b1;
            pc_nxt = issue_addr_i;
            st_nxt = UBK_IDLE;
          end
        end
        UBK_SLOT: begin
          if (issue_ok) begin
            st_nxt = UBK_TARGET;
          end
        end
        UBK_TARGET: begin
          if (issue_ok) begin
            // Branch target is held off; the branch address is saved.
            trap_nxt = 1'b1;
            pc_nxt = held_pc_r;
            st_nxt = UBK_IDLE;
          end
        end
        default: begin
          st_nxt = UBK_IDLE;
        end
      endcase
      if (!trap_nxt && aft_hit) begin
        if (issue_is_dbranch_i) begin
          st_nxt = UBK_SLOT;
          held_pc_nxt = issue_addr_i;
        end else begin
          st_nxt = UBK_NEXT;
        end
      end else if (!trap_nxt && dat_hit && st_nxt == UBK_IDLE) begin
        st_nxt = UBK_NEXT;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st_r <= UBK_IDLE;
      held_pc_r <= REG_RST;
    end else if (manual_rst_i) begin
      st_r <= UBK_IDLE;
      held_pc_r <= REG_RST;
    end else begin
      st_r <= st_nxt;
      held_pc_r <= held_pc_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      brk_trap_o <= 1'b0;
      brk_saved_pc_o <= REG_RST;
    end else begin
      brk_trap_o <= trap_nxt & ~manual_rst_i;
      // A suppressed trap leaves the saved address untouched.
      if (!manual_rst_i) begin
        brk_saved_pc_o <= pc_nxt;
      end
    end
  end

endmodule

// ---- bench/ubk_user_break_sva.sv ----
// Port-level checker for the user break unit.
// Assumes it is bound to ubk_user_break; one clock, asynchronous active-low reset.
`timescale 1ns/100ps
module ubk_user_break_sva
  import ubk_pkg::*;
(
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  // Register bus.
  input wire logic [ubk_pkg::BAW-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [ubk_pkg::DW-1:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Core side.
  input wire logic issue_valid_i,
  input wire logic issue_excp_i,
  input wire logic issue_in_slot_i,
  input wire logic [ubk_pkg::AW-1:0] issue_branch_addr_i,
  input wire logic brk_trap_o,
  input wire logic [ubk_pkg::AW-1:0] brk_saved_pc_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!nrst_i);
  ////////////////////////////////////////////////////////////////////////////////
  chk_trap_pulse: assert property (brk_trap_o |=> !brk_trap_o)
    else $error("trap request longer than one cycle");
  chk_trap_cause: assert property (brk_trap_o |-> $past(issue_valid_i) && !$past(issue_excp_i))
    else $error("trap without a confirmed issue");
  chk_excp_skip: assert property (issue_valid_i && issue_excp_i |=> !brk_trap_o)
    else $error("trap on an excepting issue");
  chk_slot_pc: assert property (brk_trap_o && $past(issue_in_slot_i)
    |-> brk_saved_pc_o == $past(issue_branch_addr_i))
    else $error("slot trap saved wrong address");
  chk_pc_hold: assert property (!brk_trap_o |-> $stable(brk_saved_pc_o))
    else $error("saved address moved without a trap");
  chk_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");
  chk_wait_back: assert property ($fell(avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  chk_ctl_reserved: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i == OFS_CONTROL |-> (avs_readdata_o & 32'hffff3b37) == 32'h0)
    else $error("reserved control bits read nonzero");
  cov_slot: cover property (brk_trap_o && $past(issue_in_slot_i));
  cov_excp: cover property (issue_valid_i && issue_excp_i);
  cov_ctl: cover property (avs_read_i && !avs_waitrequest_o && avs_address_i == OFS_CONTROL);
endmodule
bind ubk_user_break ubk_user_break_sva i_sva (
  .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .issue_valid_i(issue_valid_i),
  .issue_excp_i(issue_excp_i), .issue_in_slot_i(issue_in_slot_i),
  .issue_branch_addr_i(issue_branch_addr_i), .brk_trap_o(brk_trap_o),
  .brk_saved_pc_o(brk_saved_pc_o)
);

// ---- bench/ubk_core_model.sv ----
// Core-side model: confirmed instruction issues and data cycles into the break unit.
// Assumes the bench calls its tasks; released buses show inverted values.
`timescale 1ns/100ps
module ubk_core_model (
  // Clock and trap response.
  input wire logic clk_i,
  input wire logic trap_i,
  input wire logic [31:0] pc_i,
  // Issue drive.
  output logic iv_o,
  output logic ie_o,
  output logic [31:0] ia_o,
  output logic [7:0] iid_o,
  output logic idb_o,
  output logic isl_o,
  output logic [31:0] iba_o,
  // Data cycle drive.
  output logic dv_o,
  output logic dw_o,
  output logic [1:0] dsz_o,
  output logic [31:0] da_o,
  output logic [7:0] did_o,
  output logic [31:0] dd_o
);
  initial begin
    {iv_o, ie_o, ia_o, iid_o, idb_o, isl_o, iba_o} = '0;
    {dv_o, dw_o, dsz_o, da_o, did_o, dd_o} = '0;
  end
  // Only instructions confirmed to execute are issued; no slot follows a return.
  task automatic issue(input logic [31:0] a, input logic [7:0] id, input logic [2:0] f,
      input logic [31:0] ba, output logic t, output logic [31:0] pc);
    @(posedge clk_i);
    {iv_o, ia_o, iid_o, ie_o, isl_o, idb_o, iba_o} <= {1'b1, a, id, f, ba};
    @(posedge clk_i);
    {iv_o, ia_o, iid_o, iba_o} <= {1'b0, ~a, ~id, ~ba};
    #1;
    t = trap_i;
    pc = pc_i;
  endtask
  task automatic dacc(input logic w, input logic [1:0] sz, input logic [31:0] a,
      input logic [7:0] id, input logic [31:0] d);
    @(posedge clk_i);
    {dv_o, dw_o, dsz_o, da_o, did_o, dd_o} <= {1'b1, w, sz, a, id, d};
    @(posedge clk_i);
    {dv_o, da_o, did_o, dd_o} <= {1'b0, ~a, ~id, ~d};
  endtask
endmodule

// ---- bench/ubk_user_break_test.sv ----
// Self-checking bench for the user break unit: register bus tasks and core model calls.
// Assumes the core model in ubk_core_model and the checker bound to the unit.
`timescale 1ns/100ps
module ubk_user_break_test;
  import ubk_pkg::*;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  logic mrst = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, saved_pc, v, pc, ia, iba, da, dd;
  logic wreq, trap, t, iv, ie, idb, isl, dv, dw;
  logic [7:0] iid, did;
  logic [1:0] dsz;
  int n_mismatch = 0;
  int checks_done = 0;
  always #20 sys_clk = ~sys_clk;
  ubk_user_break i_dut (.sys_clk_i(sys_clk), .nrst_i(nrst), .manual_rst_i(mrst),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
    .issue_valid_i(iv), .issue_excp_i(ie), .issue_addr_i(ia), .issue_asid_i(iid),
    .issue_is_dbranch_i(idb), .issue_in_slot_i(isl), .issue_branch_addr_i(iba),
    .dacc_valid_i(dv), .dacc_write_i(dw), .dacc_size_i(dsz), .dacc_addr_i(da),
    .dacc_asid_i(did), .dacc_data_i(dd), .brk_trap_o(trap), .brk_saved_pc_o(saved_pc));
  ubk_core_model i_core (.clk_i(sys_clk), .trap_i(trap), .pc_i(saved_pc), .iv_o(iv), .ie_o(ie),
    .ia_o(ia), .iid_o(iid), .idb_o(idb), .isl_o(isl), .iba_o(iba), .dv_o(dv), .dw_o(dw),
    .dsz_o(dsz), .da_o(da), .did_o(did), .dd_o(dd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One access; waitrequest and read data are taken at the rising edge that sees the answer,
  // and the request is released by the same edge so it is never taken twice.
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    {addr, wr, rd, wdata} <= {a, w, !w, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    v = rdata;
    if (n >= 50) n_mismatch++;
    {wr, rd} <= 2'b00;
  endtask
  task automatic rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(v, e);
  endtask
  task automatic iss(input logic [31:0] a, input logic [7:0] id, input logic [2:0] f,
      input logic [31:0] ba, input logic et, input logic [31:0] epc);
    i_core.issue(a, id, f, ba, t, pc);
    chk({31'h0, t}, {31'h0, et});
    if (et) chk(pc, epc);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk);
    nrst <= 1'b1;
    rdc(OFS_CONTROL, 32'h0);
    rdc(6'h3c, 32'h0);
    bus(1'b1, OFS_ADDR_A, 32'h404);
    bus(1'b1, OFS_SPACE_A, 32'h80);
    iss(32'h404, 8'h80, 3'b000, 32'h0, 1'b0, 32'h0);
    bus(1'b1, OFS_CYC_A, 32'h16);
    iss(32'h404, 8'h80, 3'b100, 32'h0, 1'b0, 32'h0);
    iss(32'h404, 8'h81, 3'b000, 32'h0, 1'b0, 32'h0);
    iss(32'h406, 8'h80, 3'b000, 32'h0, 1'b0, 32'h0);
    iss(32'h404, 8'h80, 3'b000, 32'h0, 1'b1, 32'h404);
    rdc(OFS_CONTROL, 32'h8000);
    rdc(OFS_CONTROL, 32'h8000);
    bus(1'b1, OFS_CONTROL, 32'h0);
    rdc(OFS_CONTROL, 32'h0);
    iss(32'h404, 8'h80, 3'b010, 32'h402, 1'b1, 32'h402);
    $display("test fetch before done");
    bus(1'b1, OFS_CONTROL, 32'h400);
    iss(32'h404, 8'h80, 3'b000, 32'h0, 1'b0, 32'h0);
    iss(32'h408, 8'h80, 3'b000, 32'h0, 1'b1, 32'h408);
    iss(32'h404, 8'h80, 3'b001, 32'h0, 1'b0, 32'h0);
    iss(32'h406, 8'h80, 3'b010, 32'h404, 1'b0, 32'h0);
    iss(32'h500, 8'h80, 3'b000, 32'h0, 1'b1, 32'h404);
    @(posedge sys_clk) mrst <= 1'b1;
    @(posedge sys_clk) mrst <= 1'b0;
    rdc(OFS_CONTROL, 32'h0);
    rdc(OFS_ADDR_A, 32'h404);
    $display("test fetch after done");
    bus(1'b1, OFS_ADDR_A, 32'h123456);
    bus(1'b1, OFS_ADDR_B, 32'habcde);
    bus(1'b1, OFS_SPACE_B, 32'h70);
    bus(1'b1, OFS_AMASK_B, 32'h2);
    bus(1'b1, OFS_DATA_B, 32'ha512);
    bus(1'b1, OFS_DMASK_B, 32'h0);
    bus(1'b1, OFS_CONTROL, 32'h80);
    bus(1'b1, OFS_CYC_A, 32'h24);
    bus(1'b1, OFS_CYC_B, 32'h2a);
    i_core.dacc(1'b0, SZ_BYTE, 32'h123457, 8'h80, 32'h0);
    iss(32'h600, 8'h80, 3'b000, 32'h0, 1'b0, 32'h0);
    i_core.dacc(1'b0, SZ_LONG, 32'h123454, 8'h80, 32'h0);
    iss(32'h602, 8'h80, 3'b000, 32'h0, 1'b1, 32'h602);
    i_core.dacc(1'b1, SZ_WORD, 32'hab010, 8'h70, 32'ha513);
    iss(32'h604, 8'h80, 3'b000, 32'h0, 1'b0, 32'h0);
    bus(1'b1, OFS_DMASK_B, 32'h1);
    i_core.dacc(1'b1, SZ_WORD, 32'hab010, 8'h70, 32'ha513);
    iss(32'h606, 8'h80, 3'b000, 32'h0, 1'b1, 32'h606);
    $display("test data done");
    bus(1'b1, OFS_CONTROL, 32'h88);
    bus(1'b1, OFS_ADDR_A, 32'h37226);
    bus(1'b1, OFS_ADDR_B, 32'h3722e);
    bus(1'b1, OFS_AMASK_B, 32'h0);
    bus(1'b1, OFS_CYC_A, 32'h16);
    bus(1'b1, OFS_CYC_B, 32'h16);
    iss(32'h3722e, 8'h70, 3'b000, 32'h0, 1'b0, 32'h0);
    iss(32'h37226, 8'h80, 3'b000, 32'h0, 1'b0, 32'h0);
    iss(32'h3722e, 8'h70, 3'b000, 32'h0, 1'b1, 32'h3722e);
    rdc(OFS_CONTROL, 32'h4088);
    $display("test sequential done");
    test_done();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    test_done();
  end
endmodule
